// ### logic/pfs_pkg.sv
/*
  Constants, register map and shared types of the fault status and
  write-protection register bank.
  Assumes a 32-bit classic Wishbone slave on a single clock.
*/
package pfs_pkg;

  localparam int unsigned NUM_FAULT = 4;
  localparam int unsigned FVAL_W    = 4;
  localparam int unsigned POL_W     = 8;

  // register byte offsets
  localparam logic [7:0] OFF_FMS      = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_FLTCTRL  = 8'h08;
  localparam logic [7:0] OFF_POL      = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // fault_mode_status fields
  localparam int unsigned FMS_SUM_BIT  = 7;
  localparam int unsigned FMS_WPON_BIT = 6;
  localparam int unsigned FMS_FIN_BIT  = 5;

  // mode register fields
  localparam int unsigned MODE_FCEN_BIT  = 0;
  localparam int unsigned MODE_WPOFF_BIT = 2;

  // fault control register fields
  localparam int unsigned FLT_EN_LSB   = 0;
  localparam int unsigned FLT_FEN_LSB  = 4;
  localparam int unsigned FLT_FVAL_LSB = 8;

  // values after reset
  localparam logic                 RST_WPOFF = 1'b1;
  localparam logic                 RST_FCEN  = 1'b0;
  localparam logic [NUM_FAULT-1:0] RST_EN    = 4'h0;
  localparam logic [FVAL_W-1:0]    RST_FVAL  = 4'h0;
  localparam logic [POL_W-1:0]     RST_POL   = 8'h00;

  typedef enum logic [1:0] {
    PFS_BUS_IDLE = 2'b01,
    PFS_BUS_ACK  = 2'b10
  } pfs_bus_state_t;

endpackage

// ### logic/pfs_reg_if.sv
/*
  Register access carrier between the Wishbone slave and the core.
  Assumes one clock; rd and wr are one-cycle strobes.
*/
interface pfs_reg_if;
  logic        rd;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;

  modport slave (output rd, wr, addr, wdata, be, input rdata);
  modport core  (input rd, wr, addr, wdata, be, output rdata);
endinterface

// ### logic/pfs_wb_slave.sv
/*
  Classic Wishbone slave: one wait state, registered ack and data.
  Assumes the master holds its request until it samples ack.
*/
module pfs_wb_slave
  import pfs_pkg::*;
(
  input  wire logic        clk_i,    // module clock
  input  wire logic        rst_i,    // synchronous reset
  input  wire logic        wb_cyc_i, // bus cycle
  input  wire logic        wb_stb_i, // strobe
  input  wire logic        wb_we_i,  // write enable
  input  wire logic [7:0]  wb_adr_i, // byte address
  input  wire logic [3:0]  wb_sel_i, // byte lanes
  input  wire logic [31:0] wb_dat_i, // write data
  output logic      [31:0] wb_dat_o, // read data
  output logic             wb_ack_o, // acknowledge
  pfs_reg_if.slave         rif       // core access
);
  typedef struct packed {
    pfs_bus_state_t st;
    logic [31:0]    dat;
  } pfs_wb_st_t;

  pfs_wb_st_t q, d;
  logic       req;

  assign req       = (q.st == PFS_BUS_IDLE) && wb_cyc_i && wb_stb_i;
  assign rif.rd    = req && !wb_we_i;
  assign rif.wr    = req && wb_we_i;
  assign rif.addr  = wb_adr_i;
  assign rif.wdata = wb_dat_i;
  assign rif.be    = wb_sel_i;
  assign wb_ack_o  = (q.st == PFS_BUS_ACK);
  assign wb_dat_o  = q.dat;

  always_comb begin
    d = q;
    unique case (q.st)
      PFS_BUS_IDLE: begin
        if (req) begin
          d.st  = PFS_BUS_ACK;
          d.dat = wb_we_i ? 32'h0000_0000 : rif.rdata;
        end
      end
      PFS_BUS_ACK: d.st = PFS_BUS_IDLE;
      default:     d.st = PFS_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{st: PFS_BUS_IDLE, dat: 32'h0000_0000};
    end else begin
      q <= d;
    end
  end
endmodule

// ### logic/pfs_fault_filter.sv
/*
  Per-input glitch filter for the fault inputs.
  Assumes inputs synchronous to clk_i; filter off when value is zero.
*/
module pfs_fault_filter #(
  parameter int unsigned N = 4,
  parameter int unsigned W = 4
) (
  input  wire logic         clk_i,    // module clock
  input  wire logic         rst_i,    // synchronous reset
  input  wire logic [N-1:0] raw_i,    // raw fault levels
  input  wire logic [N-1:0] fen_i,    // per-input filter enable
  input  wire logic [W-1:0] fval_i,   // filter length in cycles
  output logic      [N-1:0] filt_o    // filtered levels
);
  if (N < 1 || W < 1) begin : g_chk
    $error("pfs_fault_filter: N and W must be at least 1");
  end

  typedef struct packed {
    logic [N-1:0]        hold;
    logic [N-1:0][W-1:0] cnt;
  } pfs_filt_st_t;

  pfs_filt_st_t q, d;

  always_comb begin
    d = q;
    for (int j = 0; j < N; j++) begin
      if (raw_i[j] == q.hold[j]) begin
        d.cnt[j] = '0;
      end else if (q.cnt[j] + 1'b1 >= fval_i) begin
        d.hold[j] = raw_i[j];
        d.cnt[j]  = '0;
      end else begin
        d.cnt[j] = W'(q.cnt[j] + 1'b1);
      end
    end
  end

  for (genvar j = 0; j < N; j++) begin : g_out
    assign filt_o[j] = (fen_i[j] && fval_i != '0) ? q.hold[j] : raw_i[j];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ### logic/pfs_top.sv
/*
  Fault status and write-protection register bank of a PWM timer.
  Holds the fault flags with their read-then-write clearing sequences,
  the write-protection pair, fault control, polarity and an interrupt.
  Assumes fault_i is synchronous to clk_i and active high.
*/
module pfs_top
  import pfs_pkg::*;
(
  input  wire logic                 clk_i,              // module clock, 100 MHz
  input  wire logic                 rst_i,              // synchronous reset, high
  input  wire logic                 wb_cyc_i,           // bus cycle
  input  wire logic                 wb_stb_i,           // strobe
  input  wire logic                 wb_we_i,            // write enable
  input  wire logic [7:0]           wb_adr_i,           // byte address
  input  wire logic [3:0]           wb_sel_i,           // byte lanes
  input  wire logic [31:0]          wb_dat_i,           // write data
  output logic      [31:0]          wb_dat_o,           // read data
  output logic                      wb_ack_o,           // acknowledge
  input  wire logic [NUM_FAULT-1:0] fault_i,            // raw fault inputs
  output logic      [NUM_FAULT-1:0] fault_flags_o,      // per-input fault flags
  output logic                      fault_summary_o,    // summary fault flag
  output logic                      fault_inputs_or_o,  // live OR of enabled faults
  output logic                      write_protect_on_o, // protection active
  output logic                      fault_ctrl_en_o,    // fault control enable
  output logic      [POL_W-1:0]     polarity_o,         // channel polarity bits
  output logic                      irq_o               // interrupt, level
);
  typedef struct packed {
    logic [NUM_FAULT-1:0] flag;
    logic [NUM_FAULT-1:0] arm;
    logic                 sum_arm;
    logic                 wp_off;
    logic                 wp_arm;
    logic                 fcen;
    logic [NUM_FAULT-1:0] in_en;
    logic [NUM_FAULT-1:0] filt_en;
    logic [FVAL_W-1:0]    fval;
    logic [POL_W-1:0]     channel_polarity_bit;
    logic [NUM_FAULT-1:0] fin_prev;
    logic [NUM_FAULT-1:0] irq_stat;
    logic [NUM_FAULT-1:0] irq_mask;
  } pfs_core_st_t;

  pfs_core_st_t         q, d;
  pfs_reg_if            rif ();
  logic [NUM_FAULT-1:0] filt;
  logic [NUM_FAULT-1:0] fin;
  logic [NUM_FAULT-1:0] new_fault;
  logic [NUM_FAULT-1:0] flag_rise;
  logic [31:0]          wmask;
  logic [31:0]          wbits;
  logic                 fms_rd;
  logic                 fms_wr;
  logic                 mode_wr;
  logic                 flt_wr;
  logic                 pol_wr;
  logic                 irqs_rd;
  logic                 irqm_wr;
  logic                 lane0;
  logic                 lane1;
  logic                 any_fin;

  pfs_wb_slave u_wb (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .rif      (rif.slave)
  );

  pfs_fault_filter #(
    .N (NUM_FAULT),
    .W (FVAL_W)
  ) u_filt (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .raw_i  (fault_i),
    .fen_i  (q.filt_en),
    .fval_i (q.fval),
    .filt_o (filt)
  );

  // decode of the single-cycle access strobes
  assign fms_rd  = rif.rd && (rif.addr == OFF_FMS);
  assign fms_wr  = rif.wr && (rif.addr == OFF_FMS);
  assign mode_wr = rif.wr && (rif.addr == OFF_MODE);
  assign flt_wr  = rif.wr && (rif.addr == OFF_FLTCTRL);
  assign pol_wr  = rif.wr && (rif.addr == OFF_POL);
  assign irqs_rd = rif.rd && (rif.addr == OFF_IRQ_STAT);
  assign irqm_wr = rif.wr && (rif.addr == OFF_IRQ_MASK);
  assign lane0   = rif.be[0];
  assign lane1   = rif.be[1];

  assign wmask = {{8{rif.be[3]}}, {8{rif.be[2]}}, {8{rif.be[1]}}, {8{rif.be[0]}}};
  assign wbits = rif.wdata & wmask;

  // gated fault levels and their fresh detections
  assign fin       = {NUM_FAULT{q.fcen}} & q.in_en & filt;
  assign any_fin   = |fin;
  assign new_fault = fin & ~q.fin_prev;

  always_comb begin
    d          = q;
    d.fin_prev = fin;

    // a status read while a flag is set arms its clearing sequence
    if (fms_rd) begin
      d.arm = q.arm | q.flag;
      if (|q.flag) begin
        d.sum_arm = 1'b1;
      end
      if (!q.wp_off) begin
        d.wp_arm = 1'b1;
      end
    end

    if (fms_wr && lane0) begin
      // zero written to an armed flag with its input quiet clears it
      for (int j = 0; j < NUM_FAULT; j++) begin
        if (!rif.wdata[j] && q.arm[j] && !fin[j]) begin
          d.flag[j] = 1'b0;
        end
      end
      // summary clear takes every input flag with it
      if (!rif.wdata[FMS_SUM_BIT] && q.sum_arm && !any_fin) begin
        d.flag = '0;
      end
      // any write ends the pending flag and summary sequences
      d.arm     = '0;
      d.sum_arm = 1'b0;
      // only a one turns protection on, a zero is ignored
      if (rif.wdata[FMS_WPON_BIT]) begin
        d.wp_off = 1'b0;
        d.wp_arm = 1'b0;
      end
    end

    if (mode_wr && lane0) begin
      if (rif.wdata[MODE_WPOFF_BIT] && q.wp_arm && !q.wp_off) begin
        d.wp_off = 1'b1;
      end
      d.wp_arm = 1'b0;
      if (q.wp_off) begin
        d.fcen = rif.wdata[MODE_FCEN_BIT];
      end
    end

    if (flt_wr && q.wp_off) begin
      if (lane0) begin
        d.in_en   = rif.wdata[FLT_EN_LSB +: NUM_FAULT];
        d.filt_en = rif.wdata[FLT_FEN_LSB +: NUM_FAULT];
      end
      if (lane1) begin
        d.fval = rif.wdata[FLT_FVAL_LSB +: FVAL_W];
      end
    end

    if (pol_wr && lane0 && q.wp_off) begin
      d.channel_polarity_bit = rif.wdata[POL_W-1:0];
    end

    // a fresh fault restarts the sequence of its own flag and the summary
    d.arm = d.arm & ~new_fault;
    if (|new_fault) begin
      d.sum_arm = 1'b0;
    end

    // hardware set wins over any clear in the same cycle
    d.flag = d.flag | fin;

    // interrupt status: read clears, a new flag sets, set wins
    if (irqs_rd) begin
      d.irq_stat = '0;
    end
    d.irq_stat = d.irq_stat | flag_rise;

    if (irqm_wr && lane0) begin
      d.irq_mask = wbits[NUM_FAULT-1:0];
    end
  end

  assign flag_rise = fin & ~q.flag;

  // read data, combinational from the current state
  always_comb begin
    rif.rdata = 32'h0000_0000;
    unique case (rif.addr)
      OFF_FMS: begin
        rif.rdata[NUM_FAULT-1:0] = q.flag;
        rif.rdata[FMS_FIN_BIT]   = any_fin;
        rif.rdata[FMS_WPON_BIT]  = !q.wp_off;
        rif.rdata[FMS_SUM_BIT]   = |q.flag;
      end
      OFF_MODE: begin
        rif.rdata[MODE_FCEN_BIT]  = q.fcen;
        rif.rdata[MODE_WPOFF_BIT] = q.wp_off;
      end
      OFF_FLTCTRL: begin
        rif.rdata[FLT_EN_LSB +: NUM_FAULT]  = q.in_en;
        rif.rdata[FLT_FEN_LSB +: NUM_FAULT] = q.filt_en;
        rif.rdata[FLT_FVAL_LSB +: FVAL_W]   = q.fval;
      end
      OFF_POL: begin
        rif.rdata[POL_W-1:0] = q.channel_polarity_bit;
      end
      OFF_IRQ_STAT: begin
        rif.rdata[NUM_FAULT-1:0] = q.irq_stat;
      end
      OFF_IRQ_MASK: begin
        rif.rdata[NUM_FAULT-1:0] = q.irq_mask;
      end
      default: begin
        rif.rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.flag     <= '0;
      q.arm      <= '0;
      q.sum_arm  <= 1'b0;
      q.wp_off   <= RST_WPOFF;
      q.wp_arm   <= 1'b0;
      q.fcen     <= RST_FCEN;
      q.in_en    <= RST_EN;
      q.filt_en  <= RST_EN;
      q.fval     <= RST_FVAL;
      q.channel_polarity_bit      <= RST_POL;
      q.fin_prev <= '0;
      q.irq_stat <= '0;
      q.irq_mask <= '0;
    end else begin
      q <= d;
    end
  end

  assign fault_flags_o      = q.flag;
  assign fault_summary_o    = |q.flag;
  assign fault_inputs_or_o  = any_fin;
  assign write_protect_on_o = !q.wp_off;
  assign fault_ctrl_en_o    = q.fcen;
  assign polarity_o         = q.channel_polarity_bit;
  assign irq_o              = |(q.irq_stat & q.irq_mask);
endmodule

// ### tb/pfs_top_checker.sv
/* Port assertions for the fault status and write-protection bank.
   Assumes it is bound to pfs_top: one clock, synchronous high reset. */
module pfs_top_checker
  import pfs_pkg::*;
(
  input wire logic                 clk_i,              // clock
  input wire logic                 rst_i,              // reset
  input wire logic                 wb_cyc_i,           // cycle
  input wire logic                 wb_stb_i,           // strobe
  input wire logic                 wb_we_i,            // write
  input wire logic [7:0]           wb_adr_i,           // address
  input wire logic [3:0]           wb_sel_i,           // lanes
  input wire logic [31:0]          wb_dat_i,           // write data
  input wire logic [31:0]          wb_dat_o,           // read data
  input wire logic                 wb_ack_o,           // ack
  input wire logic [NUM_FAULT-1:0] fault_i,            // faults
  input wire logic [NUM_FAULT-1:0] fault_flags_o,      // flags
  input wire logic                 fault_summary_o,    // summary
  input wire logic                 fault_inputs_or_o,  // live or
  input wire logic                 write_protect_on_o, // protection
  input wire logic                 fault_ctrl_en_o,    // fault control
  input wire logic [POL_W-1:0]     polarity_o,         // polarity
  input wire logic                 irq_o               // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       take, rd_fms, wr_fms, wr_off;
  logic [4:0] quiet_q;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_fms = take && !wb_we_i && wb_adr_i == OFF_FMS;
  assign wr_fms = take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_FMS;
  assign wr_off = take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_MODE && wb_dat_i[MODE_WPOFF_BIT];
  // consecutive cycles with every raw fault input low, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || fault_i != 4'h0) begin
      quiet_q <= 5'h00;
    end else if (quiet_q != 5'h1F) begin
      quiet_q <= quiet_q + 5'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_answer;
    take ##1 wb_ack_o;
  endsequence
  sequence s_protect_req;
    wr_fms && wb_dat_i[FMS_WPON_BIT];
  endsequence
  AST_ACK_TAKE: assert property (take |-> s_answer) else $error("no ack after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  AST_FMS_READ: assert property (rd_fms |=> wb_dat_o[31:8] == 24'h000000 && !wb_dat_o[4]
    && wb_dat_o[3:0] == $past(fault_flags_o) && wb_dat_o[6] == $past(write_protect_on_o)
    && wb_dat_o[7] == |wb_dat_o[3:0] && wb_dat_o[5] == $past(fault_inputs_or_o))
    else $error("status read value wrong");
  AST_SUM_OR: assert property (fault_summary_o == |fault_flags_o) else $error("summary not or");
  AST_FLAG_SET: assert property (fault_inputs_or_o |=> fault_summary_o) else $error("flag not set");
  // a filtered input may hold its level for up to the longest filter length
  AST_FIN_GATE: assert property (fault_inputs_or_o |-> fault_ctrl_en_o
    && (fault_i != 4'h0 || quiet_q < (2**FVAL_W - 1))) else $error("live or without fault");
  AST_FLAG_CLR: assert property (|($past(fault_flags_o) & ~fault_flags_o) |-> $past(wr_fms))
    else $error("flag cleared without write");
  AST_ONE_KEEPS: assert property (wr_fms && wb_dat_i[FMS_SUM_BIT] |=>
    ($past(fault_flags_o) & $past(wb_dat_i[3:0]) & ~fault_flags_o) == 4'h0) else $error("one cleared flag");
  AST_WP_SET: assert property (s_protect_req |=> write_protect_on_o) else $error("protect not set");
  AST_WP_CLR: assert property ($fell(write_protect_on_o) |-> $past(wr_off)) else $error("protect lost");
  AST_WP_ZERO: assert property (wr_fms && !wb_dat_i[FMS_WPON_BIT] && write_protect_on_o |=>
    write_protect_on_o) else $error("zero cleared protect");
  AST_POL_LOCK: assert property (write_protect_on_o |=> $stable(polarity_o)) else $error("pol changed");
endmodule

bind pfs_top pfs_top_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fault_i(fault_i), .fault_flags_o(fault_flags_o),
  .fault_summary_o(fault_summary_o), .fault_inputs_or_o(fault_inputs_or_o),
  .write_protect_on_o(write_protect_on_o), .fault_ctrl_en_o(fault_ctrl_en_o), .polarity_o(polarity_o),
  .irq_o(irq_o));

// ### tb/pwm_fault_status_protect_test.sv
/* Self-checking bench for the fault status and write-protection bank.
   Assumes pfs_top with its bound checker; the bench drives bus and faults. */
module pwm_fault_status_protect_test import pfs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        fsum, fin, wpon, fcen, irq_o;
  logic [7:0]  wb_adr_i, channel_polarity_bit;
  logic [3:0]  wb_sel_i, fault_i, flags, exp_fl, sel_v;
  logic [31:0] wb_dat_i, wb_dat_o, rd_v, seed, v;
  int          miscompares, comparisons;

  pfs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fault_i(fault_i), .fault_flags_o(flags), .fault_summary_o(fsum), .fault_inputs_or_o(fin),
    .write_protect_on_o(wpon), .fault_ctrl_en_o(fcen), .polarity_o(channel_polarity_bit), .irq_o(irq_o));

  always #5 clk_i = ~clk_i;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] fault_mode_status(input logic [3:0] f, input logic live, input logic wp);
    return {24'h000000, |f, wp, live, 1'b0, f};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one classic cycle, held until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel_v;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      complete_run();
    end
    rd_v = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(name, rd_v, exp);
  endtask

  task automatic setf(input logic [3:0] f);
    @(posedge clk_i);
    fault_i <= f;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  initial begin
    #200us;
    miscompares++;
    complete_run();
  end

  initial begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, fault_i} = '0;
    {miscompares, comparisons, exp_fl} = '0;
    sel_v = 4'hF;
    rst_i = 1'b1;
    seed = 32'h1D;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    rd("fms", OFF_FMS, fault_mode_status(4'h0, 1'b0, 1'b0));
    rd("mode", OFF_MODE, 32'h4);
    wr(8'h18, 32'hFFFFFFFF);
    rd("unmapped", 8'h18, 32'h0);
    wr(OFF_MODE, 32'h5);
    check("fcen", fcen, 1'b1);
    wr(OFF_FLTCTRL, 32'hF);
    wr(OFF_IRQ_MASK, 32'hF);
    setf(4'h4);
    tick(2);
    rd("fms", OFF_FMS, fault_mode_status(4'h4, 1'b1, 1'b0));
    check("irq", irq_o, 1'b1);
    wr(OFF_FMS, 32'h0);
    check("flags", flags, 4'h4);
    setf(4'h0);
    wr(OFF_FMS, 32'h0);
    check("flags", flags, 4'h4);
    rd("fms", OFF_FMS, fault_mode_status(4'h4, 1'b0, 1'b0));
    wr(OFF_FMS, 32'h8F);
    check("flags", {wpon, flags}, 5'h04);
    rd("fms", OFF_FMS, fault_mode_status(4'h4, 1'b0, 1'b0));
    setf(4'h4);
    setf(4'h0);
    wr(OFF_FMS, 32'h0);
    check("flags", flags, 4'h4);
    rd("fms", OFF_FMS, fault_mode_status(4'h4, 1'b0, 1'b0));
    wr(OFF_FMS, 32'h0);
    check("flags", {fsum, flags}, 5'h00);
    rd("irqst", OFF_IRQ_STAT, 32'h4);
    check("irq", irq_o, 1'b0);
    wr(OFF_IRQ_MASK, 32'h0);
    setf(4'h1);
    setf(4'h2);
    setf(4'h0);
    tick(2);
    check("irq", irq_o, 1'b0);
    wr(OFF_IRQ_MASK, 32'hF);
    check("irq", irq_o, 1'b1);
    rd("irqst", OFF_IRQ_STAT, 32'h3);
    rd("fms", OFF_FMS, fault_mode_status(4'h3, 1'b0, 1'b0));
    wr(OFF_FMS, 32'h82);
    rd("fms", OFF_FMS, fault_mode_status(4'h2, 1'b0, 1'b0));
    wr(OFF_FMS, 32'h80);
    check("flags", {fsum, flags}, 5'h00);
    wr(OFF_FMS, 32'h40);
    wr(OFF_POL, 32'hA5);
    check("pol", channel_polarity_bit, 8'h00);
    wr(OFF_MODE, 32'h4);
    check("fcen", fcen, 1'b1);
    rd("fms", OFF_FMS, fault_mode_status(4'h0, 1'b0, 1'b1));
    rd("mode", OFF_MODE, 32'h1);
    wr(OFF_MODE, 32'h5);
    rd("mode", OFF_MODE, 32'h5);
    for (int i = 0; i < 16; i++) begin
      v = xs();
      wr(OFF_POL, v);
      check("pol", channel_polarity_bit, v[7:0]);
      setf(v[11:8]);
      tick(2);
      exp_fl = exp_fl | v[11:8];
      check("flags", flags, exp_fl);
      check("live", fin, |v[11:8]);
    end
    setf(4'h0);
    rd("fms", OFF_FMS, fault_mode_status(exp_fl, 1'b0, 1'b0));
    wr(OFF_FMS, 32'h0);
    check("flags", flags, 4'h0);
    wr(OFF_FLTCTRL, 32'h38F);
    setf(4'h8);
    setf(4'h0);
    tick(5);
    check("filt", flags, 4'h0);
    setf(4'h8);
    tick(6);
    check("filt", flags, 4'h8);
    // only byte lane 0 written: the filter length must survive
    sel_v = 4'h1;
    wr(OFF_FLTCTRL, 32'h50F);
    sel_v = 4'hF;
    rd("fltctrl", OFF_FLTCTRL, 32'h30F);
    complete_run();
  end
endmodule
